// ===== common/gain_switch_pkg.sv
/*
  Constants for the servo gain switching selector: object indices,
  reset values, mode encodings, timing and state types.
  Assumes a single 125 MHz control clock.
*/
package gain_switch_pkg;
  // Object dictionary indices
  localparam logic [15:0] IDX_POS_LOOP_GAIN1  = 16'h3100;
  localparam logic [15:0] IDX_POS_LOOP_GAIN2  = 16'h3105;
  localparam logic [15:0] IDX_OPSEL           = 16'h3114;
  localparam logic [15:0] IDX_POS_MODE        = 16'h3115;
  localparam logic [15:0] IDX_RETURN_DELAY    = 16'h3116;
  localparam logic [15:0] IDX_SWITCH_LEVEL    = 16'h3117;
  localparam logic [15:0] IDX_SWITCH_HYST     = 16'h3118;
  localparam logic [15:0] IDX_RAMP_TIME       = 16'h3119;
  localparam logic [15:0] IDX_SPEED_MODE      = 16'h3120;
  localparam logic [15:0] IDX_TLIM_SEL        = 16'h3521;

  // Reset values
  localparam logic [15:0] RST_POS_LOOP_GAIN1  = 16'h0000;
  localparam logic [15:0] RST_POS_LOOP_GAIN2  = 16'h0000;
  localparam logic [15:0] RST_OPSEL           = 16'h0001;
  localparam logic [15:0] RST_POS_MODE        = 16'h0000;
  localparam logic [15:0] RST_RETURN_DELAY    = 16'h0032;
  localparam logic [15:0] RST_SWITCH_LEVEL    = 16'h0032;
  localparam logic [15:0] RST_SWITCH_HYST     = 16'h0021;
  localparam logic [15:0] RST_RAMP_TIME       = 16'h0021;
  localparam logic [15:0] RST_SPEED_MODE      = 16'h0000;
  localparam logic [15:0] RST_TLIM_SEL        = 16'h0000;

  // Operating mode selection
  localparam logic [15:0] OPSEL_SWITCHING     = 16'h0001;

  // Position control switching modes
  localparam logic [15:0] PM_FIXED1           = 16'h0000;
  localparam logic [15:0] PM_FIXED2           = 16'h0001;
  localparam logic [15:0] PM_COMMAND          = 16'h0002;
  localparam logic [15:0] PM_CMD_TORQUE       = 16'h0003;
  localparam logic [15:0] PM_FIXED1_ALT       = 16'h0004;
  localparam logic [15:0] PM_CMD_SPEED        = 16'h0005;
  localparam logic [15:0] PM_POS_ERROR        = 16'h0006;
  localparam logic [15:0] PM_POS_CMD          = 16'h0007;
  localparam logic [15:0] PM_ACT_SPEED        = 16'h0009;
  localparam logic [15:0] PM_CMD_AND_SPEED    = 16'h000A;

  // Speed control switching modes kept here
  localparam logic [15:0] SM_FIXED1           = 16'h0000;
  localparam logic [15:0] SM_FIXED2           = 16'h0001;
  localparam logic [15:0] SM_COMMAND          = 16'h0002;

  // Torque limit selections that pin gain 1 in speed control command mode
  localparam logic [15:0] TLIM_PIN_A          = 16'h0003;
  localparam logic [15:0] TLIM_PIN_B          = 16'h0006;

  // Timing: delay and ramp settings count 0.1 ms steps
  localparam int          CLK_PERIOD_PS       = 8000;
  localparam int          STEP_TIME_PS        = 100000000;
  localparam int          STEP_CYCLES         =
    (STEP_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum logic [1:0] {
    HOLD_G1,
    HOLD_G2,
    RETURNING
  } sel_state_t;
endpackage

// ===== common/ramp_if.sv
/*
  Carrier between the selector and the position loop gain ramp.
  Assumes both ends run on the same control clock.
*/
interface ramp_if;
  logic        step_tick;
  logic [15:0] target_gain;
  logic [15:0] ramp_time;
  logic [15:0] gain;

  modport ctrl (
    output step_tick,
    output target_gain,
    output ramp_time,
    input  gain
  );
  modport ramp (
    input  step_tick,
    input  target_gain,
    input  ramp_time,
    output gain
  );
endinterface

// ===== dv/gain_switch_properties.sv
/*
  Port checker for gain_switch_select. Mirrors the mode settings from
  the object writes it sees; assumes no other path changes them.
*/
module gain_switch_properties
  import gain_switch_pkg::*;
#(
  parameter int STEP_CYCLES_P = STEP_CYCLES
)
(
  input wire logic        clock,
  input wire logic        srst,
  input wire logic [15:0] obj_index,
  input wire logic        obj_wr,
  input wire logic [15:0] obj_wdata,
  input wire logic        obj_rd,
  input wire logic [15:0] obj_rdata,
  input wire logic        speed_control,
  input wire logic        gain_sel_cmd,
  input wire logic        gain_set2,
  input wire logic        integral_action_toggle,
  input wire logic [15:0] pos_loop_gain
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] opsel_m, pmode_m, smode_m, tlim_m, g1_m, g2_m, ramp_m;
  logic [2:0]  qt;
  int          rc;
  wire         sel_on = opsel_m == OPSEL_SWITCHING;
  wire         cfg_ok = qt >= 3'h3;
  wire         pos_g1 = pmode_m == PM_FIXED1 || pmode_m == PM_FIXED1_ALT
                     || pmode_m == 16'h0008 || pmode_m > PM_CMD_AND_SPEED;
  wire         force_g1 = !sel_on || (!speed_control && pos_g1)
                       || (speed_control && smode_m == SM_FIXED1);
  wire         force_g2 = sel_on && (speed_control ? smode_m == SM_FIXED2
                                                   : pmode_m == PM_FIXED2);
  wire         tlim_pin = tlim_m == TLIM_PIN_A || tlim_m == TLIM_PIN_B;

  always_ff @(posedge clock) begin
    if (srst) begin
      opsel_m <= RST_OPSEL;
      pmode_m <= RST_POS_MODE;
      smode_m <= RST_SPEED_MODE;
      tlim_m  <= RST_TLIM_SEL;
      g1_m    <= RST_POS_LOOP_GAIN1;
      g2_m    <= RST_POS_LOOP_GAIN2;
      ramp_m  <= RST_RAMP_TIME;
    end else if (obj_wr) begin
      case (obj_index)
        IDX_OPSEL:         opsel_m <= obj_wdata;
        IDX_POS_MODE:      pmode_m <= obj_wdata;
        IDX_SPEED_MODE:    smode_m <= obj_wdata;
        IDX_TLIM_SEL:      tlim_m  <= obj_wdata;
        IDX_POS_LOOP_GAIN1: g1_m   <= obj_wdata;
        IDX_POS_LOOP_GAIN2: g2_m   <= obj_wdata;
        IDX_RAMP_TIME:     ramp_m  <= obj_wdata;
        default: ;
      endcase
    end
  end

  // Settling window after any setting or control mode change
  always_ff @(posedge clock) begin
    if (srst || obj_wr || $changed(speed_control)) qt <= 3'h0;
    else if (qt != 3'h7) qt <= qt + 3'h1;
  end

  always_ff @(posedge clock) begin
    if (srst || obj_wr || !gain_set2 || pos_loop_gain == g2_m) rc <= 0;
    else rc <= rc + 1;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  reset_clear_a: assert property (disable iff (1'b0) srst |=>
    obj_rdata == 16'h0000 && !gain_set2 && pos_loop_gain == 16'h0000)
    else $error("outputs not cleared by reset");
  rdata_hold_a: assert property (!obj_rd |=> $stable(obj_rdata))
    else $error("read data moved without a read");
  integral_sel_a: assert property (cfg_ok |->
    integral_action_toggle == !sel_on)
    else $error("integral toggle disagrees with selection");
  forced_gain1_a: assert property (cfg_ok && force_g1 |-> !gain_set2)
    else $error("gain set 2 in a gain 1 mode");
  fixed_gain2_a: assert property (cfg_ok && force_g2 |-> gain_set2)
    else $error("gain set 1 in fixed gain 2 mode");
  command_bit_a: assert property (cfg_ok && sel_on && !speed_control
    && pmode_m == PM_COMMAND && $stable(gain_sel_cmd)
    |-> gain_set2 == gain_sel_cmd)
    else $error("gain set does not follow command bit");
  speed_pin_a: assert property (cfg_ok && sel_on && speed_control
    && smode_m == SM_COMMAND && tlim_pin |-> !gain_set2)
    else $error("limit selection did not pin gain 1");
  drop_now_a: assert property ($fell(gain_set2)
    && g1_m < g2_m |-> ##[1:3] pos_loop_gain == g1_m)
    else $error("gain decrease was not immediate");
  rise_bound_a: assert property (
    rc <= (int'(ramp_m) + 1) * STEP_CYCLES_P + 4)
    else $error("gain increase overran switching time");
endmodule

bind gain_switch_select gain_switch_properties #(
  .STEP_CYCLES_P(STEP_CYCLES_P)
) gain_switch_properties_inst (
  .clock(clock), .srst(srst), .obj_index(obj_index), .obj_wr(obj_wr),
  .obj_wdata(obj_wdata), .obj_rd(obj_rd), .obj_rdata(obj_rdata),
  .speed_control(speed_control), .gain_sel_cmd(gain_sel_cmd),
  .gain_set2(gain_set2), .integral_action_toggle(integral_action_toggle),
  .pos_loop_gain(pos_loop_gain)
);

// ===== dv/host_model.sv
/*
  Host controller model: object writes, object reads and the gain
  select command bit. Assumes the selector samples on rising edges.
*/
module host_model
  import gain_switch_pkg::*;
(
  input  wire logic        clock,
  input  wire logic [15:0] obj_rdata,
  output logic      [15:0] obj_index,
  output logic             obj_wr,
  output logic      [15:0] obj_wdata,
  output logic             obj_rd,
  output logic             gain_sel_cmd
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    obj_index    = 16'h0000;
    obj_wr       = 1'b0;
    obj_wdata    = 16'h0000;
    obj_rd       = 1'b0;
    gain_sel_cmd = 1'b0;
  end

  // Released lines show the inverse so stale values never look valid
  task automatic wr(input logic [15:0] idx, input logic [15:0] d);
    @(posedge clock);
    obj_index <= idx;
    obj_wdata <= d;
    obj_wr    <= 1'b1;
    @(posedge clock);
    obj_wr    <= 1'b0;
    obj_index <= ~idx;
    obj_wdata <= ~d;
  endtask

  task automatic rd(input logic [15:0] idx, output logic [15:0] d);
    @(posedge clock);
    obj_index <= idx;
    obj_rd    <= 1'b1;
    @(posedge clock);
    obj_rd    <= 1'b0;
    obj_index <= ~idx;
    #1;
    d = obj_rdata;
  endtask

  task automatic cmd(input logic b);
    @(posedge clock);
    gain_sel_cmd <= b;
  endtask
endmodule

// ===== dv/tb_top.sv
/*
  Testbench for gain_switch_select driven through the host model.
  Assumes a 4-cycle step tick in place of 0.1 ms.
*/
`define CHK(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end

module tb_top
  import gain_switch_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] obj_index, obj_wdata, obj_rdata, pos_loop_gain, rv;
  logic [15:0] cmd_torque_pct, cmd_speed, act_speed;
  logic [15:0] pos_err_motor, pos_err_external;
  logic        clock, srst, obj_wr, obj_rd, gain_sel_cmd, gain_set2;
  logic        speed_control, fully_closed, pos_cmd_present;
  logic        integral_action_toggle;
  int          n_errors = 0;
  int          n_tests = 0;
  logic [15:0] ridx [8] = '{IDX_RETURN_DELAY, IDX_SWITCH_LEVEL,
    IDX_SWITCH_HYST, IDX_RAMP_TIME, IDX_SPEED_MODE, IDX_OPSEL,
    IDX_POS_MODE, 16'h3130};
  logic [15:0] rexp [8] = '{16'h0032, 16'h0032, 16'h0021, 16'h0021,
    16'h0000, 16'h0001, 16'h0000, 16'h0000};
  logic [15:0] md [8] = '{16'h0000, 16'h0001, 16'h0002, 16'h0002,
    16'h0004, 16'h0008, 16'h000B, 16'h0001};
  logic        cm [8] = '{1, 0, 0, 1, 1, 1, 1, 0};
  logic        ex [8] = '{0, 1, 0, 1, 0, 0, 0, 1};
  logic [15:0] mm [6] = '{PM_CMD_SPEED, PM_ACT_SPEED, PM_POS_ERROR,
    PM_POS_ERROR, PM_POS_CMD, PM_CMD_AND_SPEED};
  int          ms [6] = '{1, 2, 3, 4, 5, 5};
  logic        fc [6] = '{0, 0, 0, 1, 0, 0};

  gain_switch_select #(.STEP_CYCLES_P(4)) gain_switch_select_inst (
    .clock(clock), .srst(srst), .obj_index(obj_index), .obj_wr(obj_wr),
    .obj_wdata(obj_wdata), .obj_rd(obj_rd), .obj_rdata(obj_rdata),
    .speed_control(speed_control), .fully_closed(fully_closed),
    .gain_sel_cmd(gain_sel_cmd), .cmd_torque_pct(cmd_torque_pct),
    .cmd_speed(cmd_speed), .act_speed(act_speed),
    .pos_err_motor(pos_err_motor), .pos_err_external(pos_err_external),
    .pos_cmd_present(pos_cmd_present), .gain_set2(gain_set2),
    .integral_action_toggle(integral_action_toggle),
    .pos_loop_gain(pos_loop_gain));
  host_model host_model_inst (
    .clock(clock), .obj_rdata(obj_rdata), .obj_index(obj_index),
    .obj_wr(obj_wr), .obj_wdata(obj_wdata), .obj_rd(obj_rd),
    .gain_sel_cmd(gain_sel_cmd));

  initial clock = 1'b0;
  always #4 clock = ~clock;

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [15:0] d);
    host_model_inst.wr(idx, d);
  endtask

  task automatic chk_rd(input logic [15:0] idx, input logic [15:0] e);
    host_model_inst.rd(idx, rv);
    `CHK(rv, e)
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Four edges cover register, decision and state latency
  task automatic settle(input logic v);
    cyc(4);
    `CHK(gain_set2, v)
  endtask

  task automatic wait_gs(input logic v, input int lim);
    for (int i = 0; i < lim && gain_set2 !== v; i++) cyc(1);
    `CHK(gain_set2, v)
  endtask

  task automatic mon(input int sel, input logic [15:0] v);
    @(posedge clock);
    case (sel)
      0: cmd_torque_pct <= v;
      1: cmd_speed <= v;
      2: act_speed <= v;
      3: pos_err_motor <= v;
      4: pos_err_external <= v;
      default: pos_cmd_present <= v[0];
    endcase
  endtask

  initial begin
    srst = 1'b1;
    {speed_control, fully_closed, pos_cmd_present} = 3'h0;
    {cmd_torque_pct, cmd_speed, act_speed} = 48'h0;
    {pos_err_motor, pos_err_external} = 32'h0;
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    foreach (ridx[i]) chk_rd(ridx[i], rexp[i]);
    $display("test reset_values done");
    wr(IDX_SWITCH_HYST, 16'h0040);
    chk_rd(IDX_SWITCH_LEVEL, 16'h0040);
    wr(IDX_SWITCH_LEVEL, 16'h0010);
    chk_rd(IDX_SWITCH_LEVEL, 16'h0040);
    wr(IDX_SWITCH_HYST, 16'h0021);
    wr(IDX_SWITCH_LEVEL, 16'h0032);
    chk_rd(IDX_SWITCH_LEVEL, 16'h0032);
    $display("test level_fixup done");
    for (int i = 0; i < 8; i++) begin
      host_model_inst.cmd(cm[i]);
      wr(IDX_POS_MODE, md[i]);
      settle(ex[i]);
    end
    wr(IDX_OPSEL, 16'h0000);
    settle(1'b0);
    `CHK(integral_action_toggle, 1'b1)
    wr(IDX_OPSEL, 16'h0001);
    settle(1'b1);
    $display("test mode_table done");
    wr(IDX_RETURN_DELAY, 16'h0003);
    wr(IDX_POS_MODE, PM_CMD_TORQUE);
    mon(0, 16'h0053);
    settle(1'b0);
    mon(0, 16'hFFAB);
    settle(1'b1);
    mon(0, 16'h0011);
    cyc(20);
    `CHK(gain_set2, 1'b1)
    mon(0, 16'h0010);
    cyc(6);
    `CHK(gain_set2, 1'b1)
    wait_gs(1'b0, 20);
    mon(0, 16'h0000);
    $display("test torque_hysteresis done");
    wr(IDX_RETURN_DELAY, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      wr(IDX_POS_MODE, mm[i]);
      fully_closed <= fc[i];
      mon(ms[i], 16'h0101);
      settle(1'b1);
      mon(ms[i], 16'h0000);
      settle(1'b0);
    end
    wr(IDX_POS_MODE, PM_POS_ERROR);
    fully_closed <= 1'b1;
    mon(3, 16'h0101);
    settle(1'b0);
    mon(3, 16'h0000);
    fully_closed <= 1'b0;
    $display("test monitored_modes done");
    // Zero time first, so loading gain 1 from reset is not ramped
    wr(IDX_RAMP_TIME, 16'h0000);
    wr(IDX_POS_LOOP_GAIN1, 16'h0010);
    wr(IDX_POS_LOOP_GAIN2, 16'h0030);
    wr(IDX_RAMP_TIME, 16'h0004);
    wr(IDX_POS_MODE, PM_FIXED1);
    settle(1'b0);
    `CHK(pos_loop_gain, 16'h0010)
    wr(IDX_POS_MODE, PM_FIXED2);
    cyc(9);
    `CHK(pos_loop_gain > 16'h0010 && pos_loop_gain < 16'h0030, 1'b1)
    for (int i = 0; i < 24 && pos_loop_gain !== 16'h0030; i++) cyc(1);
    `CHK(pos_loop_gain, 16'h0030)
    wr(IDX_POS_MODE, PM_FIXED1);
    cyc(4);
    `CHK(pos_loop_gain, 16'h0010)
    $display("test gain_ramp done");
    @(posedge clock) speed_control <= 1'b1;
    wr(IDX_SPEED_MODE, SM_FIXED2);
    settle(1'b1);
    wr(IDX_OPSEL, 16'h0000);
    settle(1'b0);
    wr(IDX_OPSEL, 16'h0001);
    wr(IDX_SPEED_MODE, SM_COMMAND);
    host_model_inst.cmd(1'b1);
    settle(1'b1);
    wr(IDX_TLIM_SEL, TLIM_PIN_A);
    settle(1'b0);
    wr(IDX_TLIM_SEL, TLIM_PIN_B);
    settle(1'b0);
    wr(IDX_TLIM_SEL, 16'h0000);
    settle(1'b1);
    $display("test speed_control done");
    wrap_up();
  end

  // Whole sequence needs well under 2000 cycles
  initial begin
    #160000;
    n_errors++;
    wrap_up();
  end
endmodule

// ===== logic/gain_switch_select.sv
/*
  Servo gain 1 / gain 2 selector with hysteresis, return delay and
  position loop gain ramp; settings reached by object index.
  Assumes the fieldbus object access and all monitored quantities are
  produced by logic on the same control clock.
*/
module gain_switch_select
  import gain_switch_pkg::*;
#(
  parameter int STEP_CYCLES_P = STEP_CYCLES
)
(
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic [15:0] obj_index,
  input  wire logic        obj_wr,
  input  wire logic [15:0] obj_wdata,
  input  wire logic        obj_rd,
  output logic      [15:0] obj_rdata,
  input  wire logic        speed_control,
  input  wire logic        fully_closed,
  input  wire logic        gain_sel_cmd,
  input  wire logic [15:0] cmd_torque_pct,
  input  wire logic [15:0] cmd_speed,
  input  wire logic [15:0] act_speed,
  input  wire logic [15:0] pos_err_motor,
  input  wire logic [15:0] pos_err_external,
  input  wire logic        pos_cmd_present,
  output logic             gain_set2,
  output logic             integral_action_toggle,
  output logic      [15:0] pos_loop_gain
);
  logic [15:0] pos_loop_gain1;
  logic [15:0] pos_loop_gain2;
  logic [15:0] gain_opsel;
  logic [15:0] pos_gain_mode;
  logic [15:0] pos_gain_return_delay;
  logic [15:0] pos_gain_switch_level;
  logic [15:0] pos_gain_switch_hysteresis;
  logic [15:0] pos_loop_gain_ramp_time;
  logic [15:0] speed_gain_switch_condition;
  logic [15:0] torque_limit_sel;

  logic [15:0] step_cnt;
  logic        step_tick;
  logic [15:0] delay_cnt;
  sel_state_t  state;
  sel_state_t  next_state;

  ramp_if rif ();

  // Object decode
  wire wr_gain1  = obj_wr && (obj_index == IDX_POS_LOOP_GAIN1);
  wire wr_gain2  = obj_wr && (obj_index == IDX_POS_LOOP_GAIN2);
  wire wr_opsel  = obj_wr && (obj_index == IDX_OPSEL);
  wire wr_pmode  = obj_wr && (obj_index == IDX_POS_MODE);
  wire wr_delay  = obj_wr && (obj_index == IDX_RETURN_DELAY);
  wire wr_level  = obj_wr && (obj_index == IDX_SWITCH_LEVEL);
  wire wr_hyst   = obj_wr && (obj_index == IDX_SWITCH_HYST);
  wire wr_ramp   = obj_wr && (obj_index == IDX_RAMP_TIME);
  wire wr_smode  = obj_wr && (obj_index == IDX_SPEED_MODE);
  wire wr_tlim   = obj_wr && (obj_index == IDX_TLIM_SEL);

  // Level is fixed up in the same cycle as the write that breaks it
  wire [15:0] next_hyst  = wr_hyst  ? obj_wdata : pos_gain_switch_hysteresis;
  wire [15:0] wr_level_v = wr_level ? obj_wdata : pos_gain_switch_level;
  wire [15:0] next_level = (wr_level_v < next_hyst) ?
                           next_hyst : wr_level_v;

  wire [15:0] rd_mux =
    (obj_index == IDX_POS_LOOP_GAIN1) ? pos_loop_gain1 :
    (obj_index == IDX_POS_LOOP_GAIN2) ? pos_loop_gain2 :
    (obj_index == IDX_OPSEL)          ? gain_opsel :
    (obj_index == IDX_POS_MODE)       ? pos_gain_mode :
    (obj_index == IDX_RETURN_DELAY)   ? pos_gain_return_delay :
    (obj_index == IDX_SWITCH_LEVEL)   ? pos_gain_switch_level :
    (obj_index == IDX_SWITCH_HYST)    ? pos_gain_switch_hysteresis :
    (obj_index == IDX_RAMP_TIME)      ? pos_loop_gain_ramp_time :
    (obj_index == IDX_SPEED_MODE)     ? speed_gain_switch_condition :
    (obj_index == IDX_TLIM_SEL)       ? torque_limit_sel :
                                        16'h0000;

  always_ff @(posedge clock) begin
    if (srst) begin
      pos_loop_gain1              <= RST_POS_LOOP_GAIN1;
      pos_loop_gain2              <= RST_POS_LOOP_GAIN2;
      gain_opsel                  <= RST_OPSEL;
      pos_gain_mode               <= RST_POS_MODE;
      pos_gain_return_delay       <= RST_RETURN_DELAY;
      pos_gain_switch_level       <= RST_SWITCH_LEVEL;
      pos_gain_switch_hysteresis  <= RST_SWITCH_HYST;
      pos_loop_gain_ramp_time     <= RST_RAMP_TIME;
      speed_gain_switch_condition <= RST_SPEED_MODE;
      torque_limit_sel            <= RST_TLIM_SEL;
      obj_rdata                   <= 16'h0000;
    end else begin
      if (wr_gain1) pos_loop_gain1 <= obj_wdata;
      if (wr_gain2) pos_loop_gain2 <= obj_wdata;
      if (wr_opsel) gain_opsel <= obj_wdata;
      if (wr_pmode) pos_gain_mode <= obj_wdata;
      if (wr_delay) pos_gain_return_delay <= obj_wdata;
      if (wr_ramp) pos_loop_gain_ramp_time <= obj_wdata;
      if (wr_smode) speed_gain_switch_condition <= obj_wdata;
      if (wr_tlim) torque_limit_sel <= obj_wdata;
      pos_gain_switch_level      <= next_level;
      pos_gain_switch_hysteresis <= next_hyst;
      if (obj_rd) obj_rdata <= rd_mux;
    end
  end

  // 0.1 ms step divider
  wire step_wrap = (step_cnt == 16'(STEP_CYCLES_P - 1));

  always_ff @(posedge clock) begin
    if (srst) begin
      step_cnt  <= 16'h0000;
      step_tick <= 1'b0;
    end else begin
      step_cnt  <= step_wrap ? 16'h0000 : step_cnt + 16'h0001;
      step_tick <= step_wrap;
    end
  end

  // Magnitudes, so signed quantities of either sign act alike
  function automatic logic [15:0] magnitude(input logic [15:0] v);
    magnitude = v[15] ? (16'h0000 - v) : v;
  endfunction

  wire [15:0] pos_err_sel = fully_closed ?
                            pos_err_external : pos_err_motor;
  wire [15:0] mag_torque  = magnitude(cmd_torque_pct);
  wire [15:0] mag_cspeed  = magnitude(cmd_speed);
  wire [15:0] mag_aspeed  = magnitude(act_speed);
  wire [15:0] mag_perr    = magnitude(pos_err_sel);

  wire [15:0] monitored =
    (pos_gain_mode == PM_CMD_TORQUE) ? mag_torque :
    (pos_gain_mode == PM_CMD_SPEED)  ? mag_cspeed :
    (pos_gain_mode == PM_POS_ERROR)  ? mag_perr :
                                       mag_aspeed;

  // Level never below hysteresis, so the low bound cannot wrap
  wire [16:0] upper = {1'b0, pos_gain_switch_level} +
                      {1'b0, pos_gain_switch_hysteresis};
  wire [15:0] lower = pos_gain_switch_level -
                      pos_gain_switch_hysteresis;
  wire        above = ({1'b0, monitored} > upper);
  wire        below = (monitored < lower);

  wire level_mode = (pos_gain_mode == PM_CMD_TORQUE) ||
                    (pos_gain_mode == PM_CMD_SPEED)  ||
                    (pos_gain_mode == PM_POS_ERROR)  ||
                    (pos_gain_mode == PM_ACT_SPEED)  ||
                    (pos_gain_mode == PM_CMD_AND_SPEED);
  wire delay_mode = level_mode ||
                    (pos_gain_mode == PM_POS_CMD);

  // Mode 10: a command raises gain 2; return needs no command and
  // slow actual speed
  wire go_up   = (pos_gain_mode == PM_POS_CMD)       ? pos_cmd_present :
                 (pos_gain_mode == PM_CMD_AND_SPEED) ? pos_cmd_present :
                                                       above;
  wire go_down = (pos_gain_mode == PM_POS_CMD)       ? !pos_cmd_present :
                 (pos_gain_mode == PM_CMD_AND_SPEED) ?
                   (!pos_cmd_present && below) : below;

  wire [16:0] next_delay = {1'b0, delay_cnt} + 17'h00001;
  wire        delay_done =
    (next_delay >= {1'b0, pos_gain_return_delay});

  always_comb begin
    next_state = state;
    if (!delay_mode) begin
      next_state = HOLD_G1;
    end else begin
      unique case (state)
        HOLD_G1: begin
          if (go_up) next_state = HOLD_G2;
        end
        HOLD_G2: begin
          if (go_down) begin
            next_state = (pos_gain_return_delay == 16'h0000) ?
                         HOLD_G1 : RETURNING;
          end
        end
        RETURNING: begin
          if (!go_down) next_state = HOLD_G2;
          else if (step_tick && delay_done) next_state = HOLD_G1;
        end
        default: next_state = HOLD_G1;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state     <= HOLD_G1;
      delay_cnt <= 16'h0000;
    end else begin
      state <= next_state;
      if (state != RETURNING) delay_cnt <= 16'h0000;
      else if (step_tick) delay_cnt <= next_delay[15:0];
    end
  end

  // Final gain set choice
  wire pos_cmd_g2 = gain_sel_cmd;
  wire pos_choice =
    (pos_gain_mode == PM_FIXED1)     ? 1'b0 :
    (pos_gain_mode == PM_FIXED1_ALT) ? 1'b0 :
    (pos_gain_mode == PM_FIXED2)     ? 1'b1 :
    (pos_gain_mode == PM_COMMAND)    ? pos_cmd_g2 :
    delay_mode ? (state != HOLD_G1) : 1'b0;

  wire tlim_pins = (torque_limit_sel == TLIM_PIN_A) ||
                   (torque_limit_sel == TLIM_PIN_B);
  wire speed_choice =
    (speed_gain_switch_condition == SM_FIXED2) ? 1'b1 :
    (speed_gain_switch_condition == SM_COMMAND) ?
      (gain_sel_cmd && !tlim_pins) : 1'b0;

  wire switching = (gain_opsel == OPSEL_SWITCHING);
  wire next_set2 = switching &&
                   (speed_control ? speed_choice : pos_choice);

  always_ff @(posedge clock) begin
    if (srst) begin
      gain_set2              <= 1'b0;
      integral_action_toggle <= 1'b0;
    end else begin
      gain_set2              <= next_set2;
      integral_action_toggle <= !switching;
    end
  end

  assign rif.step_tick   = step_tick;
  assign rif.ramp_time   = pos_loop_gain_ramp_time;
  assign rif.target_gain = gain_set2 ? pos_loop_gain2 :
                                       pos_loop_gain1;

  pos_gain_ramp u_ramp (
    .clock (clock),
    .srst  (srst),
    .rp    (rif.ramp)
  );

  always_ff @(posedge clock) begin
    if (srst) pos_loop_gain <= 16'h0000;
    else pos_loop_gain <= rif.gain;
  end
endmodule

// ===== logic/pos_gain_ramp.sv
/*
  Position loop gain ramp: rises toward a larger target over the
  programmed time, drops to a smaller target at once.
  Assumes a one-cycle step tick every 0.1 ms from the selector.
*/
module pos_gain_ramp
  import gain_switch_pkg::*;
(
  input  wire logic clock,
  input  wire logic srst,
  ramp_if.ramp      rp
);
  logic [15:0] tgt_q;
  logic [15:0] span;
  logic [31:0] acc;
  logic [15:0] elapsed;
  logic        ramping;

  wire         new_target = (rp.target_gain != tgt_q);
  wire         go_now     = (rp.target_gain <= rp.gain) ||
                            (rp.ramp_time == 16'h0000);
  wire  [16:0] next_elapsed = {1'b0, elapsed} + 17'h00001;
  wire         ramp_done  = (next_elapsed >= {1'b0, rp.ramp_time});
  wire         can_step   = (acc >= {16'h0000, rp.ramp_time}) &&
                            (rp.gain < tgt_q);

  always_ff @(posedge clock) begin
    if (srst) begin
      rp.gain <= 16'h0000;
      tgt_q   <= 16'h0000;
      span    <= 16'h0000;
      acc     <= 32'h0000_0000;
      elapsed <= 16'h0000;
      ramping <= 1'b0;
    end else if (new_target) begin
      tgt_q   <= rp.target_gain;
      acc     <= 32'h0000_0000;
      elapsed <= 16'h0000;
      span    <= rp.target_gain - rp.gain;
      if (go_now) begin
        rp.gain <= rp.target_gain;
        ramping <= 1'b0;
      end else begin
        ramping <= 1'b1;
      end
    end else if (ramping) begin
      if (rp.step_tick) begin
        elapsed <= next_elapsed[15:0];
        if (ramp_done) begin
          rp.gain <= tgt_q;
          ramping <= 1'b0;
        end else begin
          acc <= acc + {16'h0000, span};
        end
      end else if (can_step) begin
        // One unit per clock; the end of the time snaps any lag
        rp.gain <= rp.gain + 16'h0001;
        acc     <= acc - {16'h0000, rp.ramp_time};
      end
    end
  end
endmodule
